// ### dv/pwm_channel_timer_align_concat_tb.sv
// Self-checking bench for the six-channel pulse-width timer block.
`timescale 1ns/1ps
`include "pwm_timer_defs.svh"

module pwm_channel_timer_align_concat_tb;
   import pwm_timer_pkg::*;

   logic        i_clk;
   logic        i_srst;
   apb_req_t    req;
   apb_rsp_t    rsp;
   logic [5:0]  pwm;
   int          errors;
   int          total_checks;
   logic [31:0] rd;
   logic        rd_err;
   int          hi_cnt;
   int          rises;
   int          stray;

   pwm_channel_timer DUT
   (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_apb  (req),
      .o_apb  (rsp),
      .o_pwm  (pwm)
   );

   // ==========================================================
   // Clock, verdict and watchdog
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic tally_and_finish();
      if (errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #(10 * 90000);
      errors++;
      tally_and_finish();
   end

   // ==========================================================
   // Bus and comparison helpers
   function automatic logic [7:0] adr(input logic [2:0] region, input logic [2:0] word);
      return {region, word, 2'b00};
   endfunction : adr

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge i_clk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge i_clk);
      end
      while (rsp.pready !== 1'b1);
      check("pready", 32'h1, 32'(rsp.pready));
      rd     = rsp.prdata;
      rd_err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer

   // ==========================================================
   // Waveform model: high time and edge count over whole periods
   task automatic measure(input int ch, input int n);
      logic prev;
      @(negedge i_clk);
      prev   = pwm[ch];
      hi_cnt = 0;
      rises  = 0;
      stray  = 0;
      repeat (n)
      begin
         @(negedge i_clk);
         if (pwm[ch] === 1'b1)
            hi_cnt++;
         if (pwm[ch] === 1'b1 && prev === 1'b0)
            rises++;
         if ((pwm & ~(6'h01 << ch)) !== 6'h00)
            stray++;
         prev = pwm[ch];
      end
   endtask : measure

   task automatic expect_wave(input int ch, input int per, input int duty, input logic ctr,
                              input logic pol, input int mult);
      int eff;
      int exp_hi;
      eff    = per * mult * (ctr ? 2 : 1);
      exp_hi = 4 * mult * (ctr ? 2 : 1) * (pol ? duty : per - duty);
      repeat (2 * eff) @(posedge i_clk);
      measure(ch, 4 * eff);
      check("high cycles", exp_hi, hi_cnt);
      check("periods", 32'h4, rises);
      check("other outputs", 32'h0, stray);
   endtask : expect_wave

   // ==========================================================
   // Main sequence
   initial
   begin
      int          per;
      int          duty;
      int          lo;
      int          hi;
      logic [31:0] c1;
      logic [5:0]  bit1;
      req    = '0;
      i_srst = 1'b1;
      errors = 0;
      total_checks = 0;
      void'($urandom(32'h1be4));
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      @(negedge i_clk);
      check("pwm after reset", 32'h0, 32'(pwm));
      for (int w = 0; w < 6; w++)
      begin
         xfer(1'b0, adr(`REGION_CTRL, w[2:0]), 32'h0);
         check("ctrl after reset", 32'h0, rd);
      end
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_SCALE), 32'h1);
      // Each channel alone, modes, polarity and clock choice from its index.
      for (int ch = 0; ch < 6; ch++)
      begin
         bit1 = 6'h01 << ch;
         per  = 4 + $urandom % 60;
         duty = 1 + $urandom % (per - 1);
         xfer(1'b1, adr(`REGION_PER, ch[2:0]), per);
         xfer(1'b1, adr(`REGION_DUTY, ch[2:0]), duty);
         xfer(1'b0, adr(`REGION_PER, ch[2:0]), 32'h0);
         check("period buffer", per, rd);
         xfer(1'b0, adr(`REGION_DUTY, ch[2:0]), 32'h0);
         check("duty buffer", duty, rd);
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_ALIGN), ch[0] ? 32'(bit1) : 32'h0);
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_POLARITY), ch[1] ? 32'(bit1) : 32'h0);
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_CLKSEL), ch[2] ? 32'(bit1) : 32'h0);
         xfer(1'b1, adr(`REGION_CNT, ch[2:0]), $urandom);
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'(bit1));
         expect_wave(ch, per, duty, ch[0], ch[1], ch[2] ? 2 : 1);
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'h0);
      end
      // Counter write while running, buffered period, hold while disabled.
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_CLKSEL), 32'h0);
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_ALIGN), 32'h0);
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_POLARITY), 32'h4);
      xfer(1'b1, adr(`REGION_PER, 3'h2), 32'd200);
      xfer(1'b1, adr(`REGION_DUTY, 3'h2), 32'd100);
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'h4);
      repeat (50) @(posedge i_clk);
      xfer(1'b1, adr(`REGION_CNT, 3'h2), 32'h5a);
      xfer(1'b0, adr(`REGION_CNT, 3'h2), 32'h0);
      check("count after write", 32'h1, 32'(rd < 8));
      @(negedge i_clk);
      check("level after write", 32'h1, 32'(pwm[2]));
      xfer(1'b1, adr(`REGION_PER, 3'h2), 32'd20);
      repeat (40) @(posedge i_clk);
      xfer(1'b0, adr(`REGION_CNT, 3'h2), 32'h0);
      check("period buffered", 32'h1, 32'(rd > 30));
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'h0);
      xfer(1'b0, adr(`REGION_CNT, 3'h2), 32'h0);
      c1 = rd;
      repeat (20) @(posedge i_clk);
      xfer(1'b0, adr(`REGION_CNT, 3'h2), 32'h0);
      check("count held", c1, rd);
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'h4);
      repeat (10) @(posedge i_clk);
      xfer(1'b0, adr(`REGION_CNT, 3'h2), 32'h0);
      check("count resumed", 32'h1, 32'(rd > c1));
      xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'h0);
      // Unmapped word.
      xfer(1'b1, 8'h18, 32'hffff);
      xfer(1'b0, 8'h18, 32'h0);
      check("unmapped error", 32'h1, 32'(rd_err));
      check("unmapped data", 32'h0, rd);
      // Joined pairs: high bytes from the lower-numbered channel.
      for (int p = 0; p < 3; p++)
      begin
         hi   = 2 * p;
         lo   = hi + 1;
         per  = 300 + $urandom % 200;
         duty = 50 + $urandom % 200;
         xfer(1'b1, adr(`REGION_PER, hi[2:0]), 32'(per[15:8]));
         xfer(1'b1, adr(`REGION_PER, lo[2:0]), 32'(per[7:0]));
         xfer(1'b1, adr(`REGION_DUTY, hi[2:0]), 32'(duty[15:8]));
         xfer(1'b1, adr(`REGION_DUTY, lo[2:0]), 32'(duty[7:0]));
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_ALIGN), 32'(6'h01 << (p[0] ? lo : hi)));
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_POLARITY), 32'(6'h01 << (p == 1 ? lo : hi)));
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_CLKSEL), 32'(6'h01 << hi));
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_PAIRING), 32'(3'h1 << p));
         xfer(1'b1, adr(`REGION_CNT, hi[2:0]), 32'h0);
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'(6'h03 << hi));
         expect_wave(lo, per, duty, p[0], p == 1, 1);
         xfer(1'b1, adr(`REGION_CNT, hi[2:0]), 32'h0);
         xfer(1'b0, adr(`REGION_CNT, lo[2:0]), 32'h0);
         check("joined count cleared", 32'h1, 32'(rd < 8));
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_ENABLE), 32'h0);
         xfer(1'b1, adr(`REGION_CTRL, `CTRL_PAIRING), 32'h0);
      end
      tally_and_finish();
   end

endmodule : pwm_channel_timer_align_concat_tb

// ### hw/pwm_channel_timer.sv
// Six 8-bit pulse-width channel timers with alignment modes and pair joining.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_timer_defs.svh"
// Overview of operation
// - Counter write while enabled restarts the period, output at polarity level.
// - Counter clears on any counter write and at end of effective period.
// - Counter holds while disabled and resumes from held value when enabled.
// - Alignment bit zero gives left-aligned, one gives center-aligned waveform.
// - Left-aligned counts up only; output flop toggles at duty match.
// - Left-aligned period match clears counter and flop, loads buffered values.
// - Left-aligned counter runs zero to period minus one.
// - Center-aligned counter direction is forced up whenever count is zero.
// - Center-aligned period match while counting up turns the counter down.
// - Center-aligned flop toggles at duty match going up and going down.
// - Center-aligned reaching zero downward turns up and loads buffered values.
// - Center-aligned effective period is twice the period value.
// - Three join bits merge pairs 4-5, 2-3, 0-1 into 16-bit channels.
// - The lower-numbered channel supplies the high bytes of a joined pair.
// - Joined pair uses low-order clock select, polarity and output pin.
// - Joined pair starts by low-order enable only; high-order output stays off.
// - Writing either counter byte of a joined pair clears all 16 bits.
// - Joined pair takes alignment from the low-order channel only.
// - Period and duty writes stay buffered while enabled until a load point.
// - Polarity one starts each cycle high; polarity zero starts it low.
// - After reset counters count up and all channels are disabled.

module pwm_channel_timer
(
   // Clock and reset.
   input  wire logic                    i_clk,
   input  wire logic                    i_srst,
   // Register bus.
   input  wire pwm_timer_pkg::apb_req_t i_apb,
   output      pwm_timer_pkg::apb_rsp_t o_apb,
   // Waveform outputs.
   output      logic [5:0]              o_pwm
);
   import pwm_timer_pkg::*;

   state_t st_reg;
   state_t st_next;

   // Per-channel views shared with the checks below.
   logic [5:0] cnt_wr;
   logic [5:0] eff_en;
   logic [5:0] eff_tick;
   logic [5:0] joined;

   // ==========================================================
   // Channel step
   // ==========================================================
   function automatic step_t chan_step
   (
      input step_t       s,
      input logic [15:0] per_b,
      input logic [15:0] duty_b,
      input logic        en,
      input logic        tick,
      input logic        clr,
      input logic        center
   );
      step_t       n;
      logic [15:0] c;
      logic        up;
      n  = s;
      c  = s.cnt;
      up = s.up;
      if (center && s.cnt == `CNT_CLEAR)
      begin
         n.up = 1'b1;
         up   = 1'b1;
      end
      if (clr)
      begin
         n.cnt  = `CNT_CLEAR;
         n.up   = 1'b1;
         n.ff   = 1'b0;
         n.per  = per_b;
         n.duty = duty_b;
      end
      else if (!en)
      begin
         n.per  = per_b;
         n.duty = duty_b;
      end
      else if (tick)
      begin
         if (s.per == `CNT_CLEAR)
            n.cnt = `CNT_CLEAR;
         else if (!center)
         begin
            c = s.cnt + `CNT_STEP;
            if (c == s.per)
            begin
               n.cnt  = `CNT_CLEAR;
               n.ff   = 1'b0;
               n.per  = per_b;
               n.duty = duty_b;
            end
            else
            begin
               n.cnt = c;
               if (c == s.duty)
                  n.ff = ~s.ff;
            end
         end
         else
         begin
            if (up && s.cnt == s.per)
            begin
               up = 1'b0;
               c  = s.cnt - `CNT_STEP;
            end
            else if (up)
               c = s.cnt + `CNT_STEP;
            else
               c = s.cnt - `CNT_STEP;
            n.cnt = c;
            n.up  = up;
            if (c == s.duty)
               n.ff = ~s.ff;
            if (!up && c == `CNT_CLEAR)
            begin
               n.up   = 1'b1;
               n.ff   = 1'b0;
               n.per  = per_b;
               n.duty = duty_b;
            end
         end
      end
      return n;
   endfunction : chan_step

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      logic                  setup;
      logic                  wr;
      logic [2:0]            region;
      logic [`CH_IDX_W-1:0]  idx;
      logic                  ch_ok;
      logic                  tick_s;
      logic [31:0]           rd;
      logic                  hit;
      int                    hi;
      step_t                 s;
      step_t                 r;
      logic [15:0]           per_b;
      logic [15:0]           duty_b;
      logic                  clr;
      setup   = i_apb.psel && !i_apb.penable;
      wr      = i_apb.psel && i_apb.penable && i_apb.pwrite;
      region  = i_apb.paddr[7:5];
      idx     = i_apb.paddr[4:2];
      ch_ok   = (idx < `CH_IDX_W'(`NUM_CH));
      st_next = st_reg;
      cnt_wr  = `RST_BITS;
      eff_en  = `RST_BITS;
      eff_tick = `RST_BITS;
      joined  = `RST_BITS;
      rd      = `RD_ZERO;
      hit     = ch_ok;
      hi      = 0;
      s       = '0;
      r       = '0;
      per_b   = `CNT_CLEAR;
      duty_b  = `CNT_CLEAR;
      clr     = 1'b0;

      // Prescaled tick: one pulse every scale+1 bus clocks.
      tick_s        = (st_reg.presc == `RST_BYTE);
      st_next.presc = tick_s ? st_reg.scale : st_reg.presc - 8'h01;

      // Register writes take effect in the access phase.
      if (wr)
      begin
         case (region)
            `REGION_CTRL:
            begin
               case (idx)
                  `CTRL_ENABLE:   st_next.channel_enable_bit  = i_apb.pwdata[5:0];
                  `CTRL_POLARITY: st_next.polarity_bit        = i_apb.pwdata[5:0];
                  `CTRL_CLKSEL:   st_next.clock_select_bit    = i_apb.pwdata[5:0];
                  `CTRL_ALIGN:    st_next.center_align_select = i_apb.pwdata[5:0];
                  `CTRL_PAIRING:  st_next.pair_join           = i_apb.pwdata[2:0];
                  `CTRL_SCALE:
                  begin
                     st_next.scale = i_apb.pwdata[7:0];
                     st_next.presc = i_apb.pwdata[7:0];
                  end
                  default: ;
               endcase
            end
            `REGION_CNT:  if (ch_ok) cnt_wr[idx] = 1'b1;
            `REGION_PER:  if (ch_ok) st_next.period_buf[idx] = i_apb.pwdata[7:0];
            `REGION_DUTY: if (ch_ok) st_next.duty_buf[idx] = i_apb.pwdata[7:0];
            default: ;
         endcase
      end

      // Channel timers; odd channels carry a joined pair.
      for (int ch = 0; ch < `NUM_CH; ch++)
      begin
         hi         = ch - 1;
         joined[ch] = st_reg.pair_join[ch / 2];
         if (joined[ch] && (ch % 2 == 0))
            st_next.pwm[ch] = 1'b0;
         else if (joined[ch])
         begin
            s.cnt  = {st_reg.channel_counter[hi], st_reg.channel_counter[ch]};
            s.per  = {st_reg.period_value[hi], st_reg.period_value[ch]};
            s.duty = {st_reg.duty_value[hi], st_reg.duty_value[ch]};
            s.up   = st_reg.count_up[ch];
            s.ff   = st_reg.out_ff[ch];
            per_b  = {st_reg.period_buf[hi], st_reg.period_buf[ch]};
            duty_b = {st_reg.duty_buf[hi], st_reg.duty_buf[ch]};
            clr    = cnt_wr[ch] || cnt_wr[hi];
            eff_en[ch]   = st_reg.channel_enable_bit[ch];
            eff_tick[ch] = st_reg.clock_select_bit[ch] ? tick_s : 1'b1;
            r = chan_step(s, per_b, duty_b, eff_en[ch], eff_tick[ch], clr,
                          st_reg.center_align_select[ch]);
            {st_next.channel_counter[hi], st_next.channel_counter[ch]} = r.cnt;
            {st_next.period_value[hi], st_next.period_value[ch]}       = r.per;
            {st_next.duty_value[hi], st_next.duty_value[ch]}           = r.duty;
            st_next.count_up[ch] = r.up;
            st_next.out_ff[ch]   = r.ff;
            st_next.pwm[ch]      = eff_en[ch] && (r.ff ^ st_reg.polarity_bit[ch]);
         end
         else
         begin
            s.cnt  = {8'h00, st_reg.channel_counter[ch]};
            s.per  = {8'h00, st_reg.period_value[ch]};
            s.duty = {8'h00, st_reg.duty_value[ch]};
            s.up   = st_reg.count_up[ch];
            s.ff   = st_reg.out_ff[ch];
            per_b  = {8'h00, st_reg.period_buf[ch]};
            duty_b = {8'h00, st_reg.duty_buf[ch]};
            eff_en[ch]   = st_reg.channel_enable_bit[ch];
            eff_tick[ch] = st_reg.clock_select_bit[ch] ? tick_s : 1'b1;
            r = chan_step(s, per_b, duty_b, eff_en[ch], eff_tick[ch], cnt_wr[ch],
                          st_reg.center_align_select[ch]);
            st_next.channel_counter[ch] = r.cnt[7:0];
            st_next.period_value[ch]    = r.per[7:0];
            st_next.duty_value[ch]      = r.duty[7:0];
            st_next.count_up[ch]        = r.up;
            st_next.out_ff[ch]          = r.ff;
            st_next.pwm[ch] = eff_en[ch] && (r.ff ^ st_reg.polarity_bit[ch]);
         end
      end

      // Read data is captured in the setup phase so it leaves a flop.
      case (region)
         `REGION_CTRL:
         begin
            hit = 1'b1;
            case (idx)
               `CTRL_ENABLE:   rd[5:0] = st_reg.channel_enable_bit;
               `CTRL_POLARITY: rd[5:0] = st_reg.polarity_bit;
               `CTRL_CLKSEL:   rd[5:0] = st_reg.clock_select_bit;
               `CTRL_ALIGN:    rd[5:0] = st_reg.center_align_select;
               `CTRL_PAIRING:  rd[2:0] = st_reg.pair_join;
               `CTRL_SCALE:    rd[7:0] = st_reg.scale;
               default:        hit     = 1'b0;
            endcase
         end
         `REGION_CNT:
         begin
            if (ch_ok)
               rd[7:0] = st_reg.channel_counter[idx];
            if (ch_ok && idx[0] && st_reg.pair_join[idx[2:1]])
               rd[15:8] = st_reg.channel_counter[idx - 3'h1];
         end
         `REGION_PER:  if (ch_ok) rd[7:0] = st_reg.period_buf[idx];
         `REGION_DUTY: if (ch_ok) rd[7:0] = st_reg.duty_buf[idx];
         default: hit = 1'b0;
      endcase
      if (setup)
      begin
         st_next.rdata  = rd;
         st_next.slverr = !hit;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         st_reg          <= '0;
         st_reg.count_up <= `RST_UP;
      end
      else
         st_reg <= st_next;
   end

   assign o_apb.prdata  = st_reg.rdata;
   assign o_apb.pready  = 1'b1;
   assign o_apb.pslverr = st_reg.slverr;
   assign o_pwm         = st_reg.pwm;

   // ==========================================================
   // Checks
   // ==========================================================
   chk_reset_idle:
   assert property (@(posedge i_clk) disable iff (1'b0)
      i_srst |=> (st_reg.channel_enable_bit == `RST_BITS) && (&st_reg.count_up))
      else $error("channels not idle and counting up after reset");

   for (genvar g = 0; g < `NUM_CH; g++)
   begin : g_chk
      chk_cnt_clear:
      assert property (@(posedge i_clk) disable iff (i_srst)
         cnt_wr[g] |=> (st_reg.channel_counter[g] == `RST_BYTE))
         else $error("counter not cleared by a counter write");
      chk_restart_lvl:
      assert property (@(posedge i_clk) disable iff (i_srst)
         (cnt_wr[g] && eff_en[g]) |=> (st_reg.pwm[g] == st_reg.polarity_bit[g]))
         else $error("restart did not drive the polarity level");
      chk_hold_off:
      assert property (@(posedge i_clk) disable iff (i_srst)
         (!st_reg.channel_enable_bit[g] && !joined[g] && !cnt_wr[g])
         |=> $stable(st_reg.channel_counter[g]))
         else $error("counter moved while disabled");
      chk_hi_off:
      assert property (@(posedge i_clk) disable iff (i_srst)
         (joined[g] && (g % 2 == 0)) |=> !st_reg.pwm[g])
         else $error("high-order output of a joined pair is active");
      chk_left_wrap:
      assert property (@(posedge i_clk) disable iff (i_srst)
         (eff_en[g] && eff_tick[g] && !joined[g] && !cnt_wr[g]
          && !st_reg.center_align_select[g] && st_reg.period_value[g] != `RST_BYTE
          && st_reg.channel_counter[g] + 8'h01 == st_reg.period_value[g])
         |=> (st_reg.channel_counter[g] == `RST_BYTE) && !st_reg.out_ff[g]
             && (st_reg.period_value[g] == $past(st_reg.period_buf[g])))
         else $error("left-aligned period end misbehaved");
      chk_left_up:
      assert property (@(posedge i_clk) disable iff (i_srst)
         (eff_en[g] && eff_tick[g] && !joined[g] && !cnt_wr[g]
          && !st_reg.center_align_select[g]
          && st_reg.channel_counter[g] + 8'h01 < st_reg.period_value[g])
         |=> (st_reg.channel_counter[g] == $past(st_reg.channel_counter[g]) + 8'h01))
         else $error("left-aligned counter did not count up");
      chk_center_turn:
      assert property (@(posedge i_clk) disable iff (i_srst)
         (eff_en[g] && eff_tick[g] && !joined[g] && !cnt_wr[g]
          && st_reg.center_align_select[g] && st_reg.count_up[g]
          && st_reg.period_value[g] != `RST_BYTE
          && st_reg.channel_counter[g] == st_reg.period_value[g])
         |=> (!st_reg.count_up[g] || st_reg.channel_counter[g] == `RST_BYTE)
             ##1 (!eff_tick[g] || !st_reg.count_up[g]
             || st_reg.channel_counter[g] == `RST_BYTE || cnt_wr[g]))
         else $error("center-aligned counter did not turn down");
      chk_center_zero:
      assert property (@(posedge i_clk) disable iff (i_srst)
         (eff_en[g] && eff_tick[g] && !joined[g] && !cnt_wr[g]
          && st_reg.center_align_select[g] && !st_reg.count_up[g]
          && st_reg.channel_counter[g] == 8'h01)
         |=> st_reg.count_up[g] && (st_reg.duty_value[g] == $past(st_reg.duty_buf[g])))
         else $error("center-aligned bottom did not reload and turn up");
   end

endmodule : pwm_channel_timer

// ### hw/pwm_timer_defs.svh
// Address map, field layout and reset constants of the channel timer block.
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH

`define NUM_CH        6
`define NUM_PAIR      3
`define CH_IDX_W      3

// Address regions: paddr[7:5] selects a region, paddr[4:2] the word in it.
`define REGION_CTRL   3'h0
`define REGION_CNT    3'h1
`define REGION_PER    3'h2
`define REGION_DUTY   3'h3

// Words of the control region.
`define CTRL_ENABLE   3'h0
`define CTRL_POLARITY 3'h1
`define CTRL_CLKSEL   3'h2
`define CTRL_ALIGN    3'h3
`define CTRL_PAIRING  3'h4
`define CTRL_SCALE    3'h5

// Reset and clear values.
`define RST_BYTE      8'h00
`define RST_BITS      6'h00
`define RST_PAIR      3'h0
`define RST_UP        6'h3f
`define CNT_CLEAR     16'h0000
`define CNT_STEP      16'h0001
`define RD_ZERO       32'h0000_0000

`endif

// ### hw/pwm_timer_pkg.sv
// Types shared by the channel timer block and its bench.
package pwm_timer_pkg;

   // APB request from the master.
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // APB answer to the master.
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   // Working view of one channel, or of one joined pair, as 16 bits.
   typedef struct packed {
      logic [15:0] cnt;
      logic        up;
      logic        ff;
      logic [15:0] per;
      logic [15:0] duty;
   } step_t;

   // Whole state of the block.
   typedef struct packed {
      logic [5:0][7:0] channel_counter;
      logic [5:0][7:0] period_value;
      logic [5:0][7:0] duty_value;
      logic [5:0][7:0] period_buf;
      logic [5:0][7:0] duty_buf;
      logic [5:0]      count_up;
      logic [5:0]      out_ff;
      logic [5:0]      pwm;
      logic [5:0]      channel_enable_bit;
      logic [5:0]      polarity_bit;
      logic [5:0]      clock_select_bit;
      logic [5:0]      center_align_select;
      logic [2:0]      pair_join;
      logic [7:0]      scale;
      logic [7:0]      presc;
      logic [31:0]     rdata;
      logic            slverr;
   } state_t;

endpackage : pwm_timer_pkg
